// ---- verilog/bsq_sequencer.sv ----
// sequencing core of a two-phase buck controller: enable, soft-start,
// dead-time handoff, power-good and fault responses.
// assumes comparator results arrive as logic levels and sw_tick pulses
// once per switching cycle for one core_clk cycle.
// Operation
// - high gate waits for switch-node trip
// - zero current: high gate after fixed delay
// - blank switch-node trip while low gate falls
// - low gate on at margin or low node
// - shutdown holds gate outputs high impedance
// - leave shutdown on both supplies and enable
// - enable input has dropout hysteresis
// - soft-start opens with 64-cycle delay
// - reference ramps linearly to setpoint
// - gates off until ramp passes feedback
// - sense offset decays to zero over window
// - coarse steps first 640 cycles, then fine
// - pre-charged output: drives enabled at end
// - power-good low until soft-start completes
// - power-good low on any fault or disable
// - undervoltage only lowers power-good, with hysteresis
// - soft-start overvoltage uses higher trip level
// - overvoltage release depends on tripping threshold
// - overvoltage forces low gates on at once
// - low gates held until overvoltage releases
// - overvoltage clear resumes without restart
// - overcurrent: gates off, wait, retry soft-start
// - sense-line fault shuts down, then restarts
`timescale 1ns/100ps

module bsq_sequencer
	import bsq_pkg::*;
#(
	parameter int NPH = 2,
	parameter int CNT_W = 16,
	parameter int HICCUP_CYC = `BSQ_HICCUP_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// switching-cycle tick
	input wire logic sw_tick,
	// supplies and threshold enable comparators
	input wire logic bias_por_ok,
	input wire logic driver_supply_por_ok,
	input wire logic threshold_enable_input_rise,
	input wire logic threshold_enable_input_fall,
	// setpoint select
	input wire logic setpoint_select_lo,
	input wire logic setpoint_select_hi,
	// soft-start and fault comparators
	input wire logic feedback_node_above_ref,
	input wire logic uv_below_lo,
	input wire logic uv_above_hi,
	input wire logic ov_above_ref,
	input wire logic ov_below_ref_rel,
	input wire logic ov_above_fixed,
	input wire logic ov_below_fixed_rel,
	input wire logic oc_trip,
	input wire logic local_output_sense_high,
	// per-phase modulator and dead-time comparators
	input wire logic [NPH-1:0] pwm_in,
	input wire logic [NPH-1:0] sw_node_trip,
	input wire logic [NPH-1:0] low_side_gate_below,
	input wire logic [NPH-1:0] high_side_gate_margin_low,
	input wire logic [NPH-1:0] sw_node_low,
	// gate commands
	output logic [NPH-1:0] high_side_gate_r,
	output logic [NPH-1:0] low_side_gate_r,
	output logic [NPH-1:0] gate_drive_oe_r,
	// reference and sense offset
	output logic [6:0] ref_code_r,
	output logic [3:0] sense_offset_r,
	// status pins
	output logic output_ok_flag_oe_r,
	output logic overvoltage_trip_r
);

	// ============================================================
	// constants
	localparam int ZC_CYC = (`BSQ_ZC_DELAY_NS * 1000 + `BSQ_CLK_PERIOD_PS - 1)
		/ `BSQ_CLK_PERIOD_PS;
	localparam int ZC_W = 4;
	localparam int NCMP = 15;
	localparam int C_BIAS = 0;
	localparam int C_DRV = 1;
	localparam int C_ENR = 2;
	localparam int C_ENF = 3;
	localparam int C_FDBK = 4;
	localparam int C_UVL = 5;
	localparam int C_UVH = 6;
	localparam int C_OVR = 7;
	localparam int C_OVRR = 8;
	localparam int C_OVF = 9;
	localparam int C_OVFR = 10;
	localparam int C_OC = 11;
	localparam int C_LS = 12;
	localparam int C_SEL0 = 13;
	localparam int C_SEL1 = 14;

	// ============================================================
	// comparator synchroniser
	logic [NCMP-1:0] cmp_raw;
	logic [NCMP-1:0] cmp_meta_r;
	logic [NCMP-1:0] cmp_r;

	assign cmp_raw = {setpoint_select_hi, setpoint_select_lo, local_output_sense_high,
		oc_trip, ov_below_fixed_rel, ov_above_fixed, ov_below_ref_rel, ov_above_ref,
		uv_above_hi, uv_below_lo, feedback_node_above_ref, threshold_enable_input_fall,
		threshold_enable_input_rise, driver_supply_por_ok, bias_por_ok};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmp_meta_r <= '0;
			cmp_r <= '0;
		end else begin
			cmp_meta_r <= cmp_raw;
			cmp_r <= cmp_meta_r;
		end
	end

	// ============================================================
	// sequencer state
	bsq_state_t st_r, st_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [6:0] ref_nxt;
	logic [3:0] ofs_nxt;
	logic passed_r, passed_nxt;
	logic en_ok_r, en_ok_nxt;
	logic uv_r, uv_nxt;
	logic ov_r, ov_nxt;
	logic src_fixed_r, src_fixed_nxt;
	logic ov_fix_d_r;
	logic pg_oe_nxt;
	logic start_ok;
	logic in_ss;
	logic ov_trip;
	logic drv_on;
	logic step_due;
	logic [CNT_W-1:0] cnt_inc;
	logic [6:0] target;
	logic [6:0] step;
	logic [7:0] ref_sum;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		ref_nxt = ref_code_r;
		ofs_nxt = sense_offset_r;
		passed_nxt = passed_r;
		src_fixed_nxt = src_fixed_r;
		cnt_inc = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
		step_due = 1'b0;
		step = '0;
		ref_sum = '0;
		target = bsq_ref_code({cmp_r[C_SEL1], cmp_r[C_SEL0]});
		// drop out only below the lower threshold
		en_ok_nxt = en_ok_r ? cmp_r[C_ENF] : cmp_r[C_ENR];
		start_ok = cmp_r[C_BIAS] && cmp_r[C_DRV] && en_ok_r
			&& !cmp_r[C_LS];
		in_ss = (st_r == BSQ_DELAY) || (st_r == BSQ_RAMP);

		// undervoltage: flag only, hysteresis between the two fractions
		uv_nxt = uv_r ? !cmp_r[C_UVH] : cmp_r[C_UVL];

		// soft-start trips above the higher of both levels
		ov_trip = in_ss ? (cmp_r[C_OVR] && cmp_r[C_OVF]) : cmp_r[C_OVR];
		ov_nxt = ov_r;
		if (st_r == BSQ_SHUT) begin
			ov_nxt = 1'b0;
		end else if (!ov_r) begin
			if (ov_trip) begin
				ov_nxt = 1'b1;
				// the level that crossed last was the higher one
				src_fixed_nxt = in_ss && !ov_fix_d_r;
			end
		end else if (src_fixed_r ? cmp_r[C_OVFR] : cmp_r[C_OVRR]) begin
			ov_nxt = 1'b0;
		end

		unique case (st_r)
			BSQ_SHUT: begin
				cnt_nxt = '0;
				ref_nxt = '0;
				ofs_nxt = '0;
				passed_nxt = 1'b0;
				if (start_ok) begin
					st_nxt = BSQ_DELAY;
					ofs_nxt = `BSQ_OFS_FULL;
				end
			end
			BSQ_DELAY: begin
				if (sw_tick) begin
					cnt_nxt = cnt_inc;
					if (cnt_inc == CNT_W'(`BSQ_DELAY_CYC)) begin
						st_nxt = BSQ_RAMP;
						cnt_nxt = '0;
					end
				end
			end
			BSQ_RAMP: begin
				if (!cmp_r[C_FDBK]) begin
					passed_nxt = 1'b1;
				end
				if (sw_tick) begin
					cnt_nxt = cnt_inc;
					if (cnt_r < CNT_W'(`BSQ_COARSE_CYC)) begin
						step_due = (cnt_inc % CNT_W'(`BSQ_COARSE_PER)) == '0;
						step = `BSQ_COARSE_STEP;
						if (((cnt_inc % CNT_W'(`BSQ_OFS_PER)) == '0) && (sense_offset_r != '0)) begin
							ofs_nxt = sense_offset_r - 4'h1;
						end
					end else begin
						step_due = (cnt_inc % CNT_W'(`BSQ_FINE_PER)) == '0;
						step = `BSQ_FINE_STEP;
					end
					if (step_due) begin
						ref_sum = {1'b0, ref_code_r} + {1'b0, step};
						ref_nxt = (ref_sum >= {1'b0, target}) ? target : ref_sum[6:0];
					end
				end
				if (ref_code_r >= target) begin
					st_nxt = BSQ_RUN;
					cnt_nxt = '0;
					ofs_nxt = '0;
				end
			end
			BSQ_RUN: begin
				// reference follows setpoint changes directly
				ref_nxt = target;
			end
			BSQ_OC_WAIT: begin
				if (sw_tick) begin
					cnt_nxt = cnt_inc;
					if (cnt_inc == CNT_W'(HICCUP_CYC)) begin
						st_nxt = BSQ_DELAY;
						cnt_nxt = '0;
						ref_nxt = '0;
						ofs_nxt = `BSQ_OFS_FULL;
						passed_nxt = 1'b0;
					end
				end
			end
		endcase

		if (st_r != BSQ_SHUT && st_r != BSQ_OC_WAIT && cmp_r[C_OC]) begin
			st_nxt = BSQ_OC_WAIT;
			cnt_nxt = '0;
			ref_nxt = '0;
			ofs_nxt = '0;
		end
		if (st_r != BSQ_SHUT && !start_ok) begin
			st_nxt = BSQ_SHUT;
			cnt_nxt = '0;
			ref_nxt = '0;
			ofs_nxt = '0;
			passed_nxt = 1'b0;
		end

		// released only in run with no fault present
		pg_oe_nxt = !((st_nxt == BSQ_RUN) && !uv_nxt && !ov_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= BSQ_SHUT;
			cnt_r <= '0;
			ref_code_r <= '0;
			sense_offset_r <= '0;
			passed_r <= 1'b0;
			en_ok_r <= 1'b0;
			uv_r <= 1'b0;
			ov_r <= 1'b0;
			src_fixed_r <= 1'b0;
			ov_fix_d_r <= 1'b0;
			output_ok_flag_oe_r <= 1'b1;
			overvoltage_trip_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ref_code_r <= ref_nxt;
			sense_offset_r <= ofs_nxt;
			passed_r <= passed_nxt;
			en_ok_r <= en_ok_nxt;
			uv_r <= uv_nxt;
			ov_r <= ov_nxt;
			src_fixed_r <= src_fixed_nxt;
			ov_fix_d_r <= cmp_r[C_OVF];
			output_ok_flag_oe_r <= pg_oe_nxt;
			overvoltage_trip_r <= ov_nxt;
		end
	end

	// ============================================================
	// dead-time gate handoff per phase
	// raw comparator levels here: a synchroniser would eat the dead time
	logic [NPH-1:0] hi_nxt;
	logic [NPH-1:0] lo_nxt;
	logic [NPH-1:0] oe_nxt;
	logic [ZC_W-1:0] zc_r [NPH];
	logic [ZC_W-1:0] zc_nxt [NPH];

	assign drv_on = (st_r == BSQ_RUN) || ((st_r == BSQ_RAMP) && passed_r);

	always_comb begin
		for (int i = 0; i < NPH; i++) begin
			hi_nxt[i] = high_side_gate_r[i];
			lo_nxt[i] = low_side_gate_r[i];
			oe_nxt[i] = 1'b1;
			zc_nxt[i] = zc_r[i];
			if (ov_r) begin
				hi_nxt[i] = 1'b0;
				lo_nxt[i] = 1'b1;
				zc_nxt[i] = '0;
			end else if (!drv_on) begin
				hi_nxt[i] = 1'b0;
				lo_nxt[i] = 1'b0;
				oe_nxt[i] = 1'b0;
				zc_nxt[i] = '0;
			end else if (pwm_in[i]) begin
				lo_nxt[i] = 1'b0;
				// trip ignored while the low gate is still falling
				if (!high_side_gate_r[i] && !low_side_gate_r[i] && low_side_gate_below[i]) begin
					if (sw_node_trip[i] || (zc_r[i] == ZC_W'(ZC_CYC - 1))) begin
						hi_nxt[i] = 1'b1;
						zc_nxt[i] = '0;
					end else begin
						zc_nxt[i] = zc_r[i] + {{(ZC_W-1){1'b0}}, 1'b1};
					end
				end else begin
					zc_nxt[i] = '0;
				end
			end else begin
				hi_nxt[i] = 1'b0;
				zc_nxt[i] = '0;
				if (!high_side_gate_r[i] && (high_side_gate_margin_low[i] || sw_node_low[i])) begin
					lo_nxt[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			high_side_gate_r <= '0;
			low_side_gate_r <= '0;
			gate_drive_oe_r <= '0;
			for (int i = 0; i < NPH; i++) begin
				zc_r[i] <= '0;
			end
		end else begin
			high_side_gate_r <= hi_nxt;
			low_side_gate_r <= lo_nxt;
			gate_drive_oe_r <= oe_nxt;
			for (int i = 0; i < NPH; i++) begin
				zc_r[i] <= zc_nxt[i];
			end
		end
	end

endmodule // bsq_sequencer

// ---- verilog/bsq_params.svh ----
// constants of the buck soft-start and fault sequencer: timing counts,
// reference codes and step sizes.
// assumes one reference lsb is 12.5 mv and counts are in switching cycles.
`ifndef BSQ_PARAMS_SVH
`define BSQ_PARAMS_SVH

// ============================================================
// soft-start timing, switching cycles
`define BSQ_DELAY_CYC 16'h0040
`define BSQ_COARSE_CYC 16'h0280
`define BSQ_WINDOW_CYC 16'h02C0
`define BSQ_HICCUP_CYC 4096
`define BSQ_COARSE_PER 16'h0020
`define BSQ_FINE_PER 16'h0010
`define BSQ_OFS_PER 16'h0050

// ============================================================
// reference steps and setpoints, 12.5 mv lsb
`define BSQ_COARSE_STEP 7'h02
`define BSQ_FINE_STEP 7'h01
`define BSQ_OFS_FULL 4'h8
`define BSQ_REF_SEL0 7'h30
`define BSQ_REF_SEL1 7'h48
`define BSQ_REF_SEL2 7'h60
`define BSQ_REF_SEL3 7'h78

// ============================================================
// dead-time handoff
`define BSQ_ZC_DELAY_NS 35
`define BSQ_CLK_PERIOD_PS 8000

`endif

// ---- verilog/bsq_pkg.sv ----
// types and the setpoint decode of the buck sequencer.
// assumes bsq_params.svh is on the include path.
`include "bsq_params.svh"

package bsq_pkg;

	// ============================================================
	// sequencer states
	typedef enum logic [4:0] {
		BSQ_SHUT = 5'b00001,
		BSQ_DELAY = 5'b00010,
		BSQ_RAMP = 5'b00100,
		BSQ_RUN = 5'b01000,
		BSQ_OC_WAIT = 5'b10000
	} bsq_state_t;

	typedef logic [6:0] bsq_ref_t;

	// ============================================================
	// setpoint select decode, hi bit first
	function automatic bsq_ref_t bsq_ref_code(input logic [1:0] sel);
		bsq_ref_t code;
		code = `BSQ_REF_SEL0;
		case (sel)
			2'b00: code = `BSQ_REF_SEL0;
			2'b01: code = `BSQ_REF_SEL1;
			2'b10: code = `BSQ_REF_SEL2;
			default: code = `BSQ_REF_SEL3;
		endcase
		return code;
	endfunction

endpackage

// ---- testbench/bsq_sequencer_sva.sv ----
// port checker of the buck sequencer
// assumes a bind onto bsq_sequencer
`timescale 1ns/100ps
module bsq_sequencer_sva #(
	parameter int NPH = 2
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [NPH-1:0] low_side_gate_below,
	input wire logic [NPH-1:0] high_side_gate_margin_low,
	input wire logic [NPH-1:0] sw_node_low,
	input logic [NPH-1:0] high_side_gate_r,
	input logic [NPH-1:0] low_side_gate_r,
	input logic [NPH-1:0] gate_drive_oe_r,
	input logic [6:0] ref_code_r,
	input logic [3:0] sense_offset_r,
	input logic output_ok_flag_oe_r,
	input logic overvoltage_trip_r
);
	// ============================================================
	// relations
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ov_held;
		overvoltage_trip_r [*2];
	endsequence
	sequence s_run_held;
		!output_ok_flag_oe_r [*2];
	endsequence
	a_gate_no_overlap: assert property ((high_side_gate_r & low_side_gate_r) == '0)
		else $error("both gates on");
	a_hiz_gates_off: assert property ((~gate_drive_oe_r & (high_side_gate_r | low_side_gate_r)) == '0)
		else $error("gate on while released");
	a_high_after_below: assert property ($rose(high_side_gate_r[0]) |->
		$past(low_side_gate_below[0]) && !$past(low_side_gate_r[0])) else $error("early high gate");
	a_low_on_cond: assert property ($rose(low_side_gate_r[0]) && !overvoltage_trip_r |->
		$past(high_side_gate_margin_low[0] | sw_node_low[0])) else $error("early low gate");
	a_ov_clamp_on: assert property (s_ov_held |->
		(&low_side_gate_r) && (&gate_drive_oe_r) && high_side_gate_r == '0) else $error("no clamp");
	a_ov_flag_low: assert property (overvoltage_trip_r |-> output_ok_flag_oe_r)
		else $error("flag released in overvoltage");
	a_run_offset_zero: assert property (!output_ok_flag_oe_r |->
		sense_offset_r == 4'h0 && ref_code_r != 7'h00) else $error("flag before start ends");
	a_run_drives_on: assert property (s_run_held |-> &gate_drive_oe_r)
		else $error("drives off in run");
	a_ramp_step_size: assert property (output_ok_flag_oe_r && $past(output_ok_flag_oe_r) &&
		ref_code_r > $past(ref_code_r) |-> 7'(ref_code_r - $past(ref_code_r)) <= 7'h02)
		else $error("ramp step too large");
endmodule // bsq_sequencer_sva

// ---- testbench/bsq_fet_model.sv ----
// power stage and gate comparators of two phases
// assumes gate commands of bsq_sequencer; one edge of comparator lag
`timescale 1ns/100ps
module bsq_fet_model (
	input wire logic core_clk,
	input wire logic zero_cur,
	input wire logic [1:0] hs,
	input wire logic [1:0] ls,
	input wire logic [1:0] oe,
	output logic [1:0] ls_below,
	output logic [1:0] node_trip,
	output logic [1:0] hs_low,
	output logic [1:0] node_low
);
	// ============================================================
	// comparators
	logic [1:0] trip_q;
	logic [1:0] ls_q;
	initial begin
		{ls_below, trip_q, hs_low, node_low} = 8'hFF;
		ls_q = 2'b00;
	end
	// coupled spike on the node while the low gate is still falling
	assign node_trip = trip_q | (ls_q & ~(ls & oe));
	always @(posedge core_clk) begin
		ls_below <= ~(ls & oe);
		ls_q <= ls & oe;
		// node swings only once the low gate is really off
		trip_q <= zero_cur ? 2'b00 : ~(ls & oe) & ls_below;
		hs_low <= ~(hs & oe);
		node_low <= ~(hs & oe);
	end
endmodule // bsq_fet_model

// ---- testbench/bsq_sequencer_tb.sv ----
// self-checking bench of the buck sequencer
// assumes bsq_fet_model on the far side and the checker bound below
`timescale 1ns/100ps
module bsq_sequencer_tb;
	import bsq_pkg::*;
	localparam int NPH = 2;
	logic core_clk = 0, rst_n = 0, sw_tick = 0, zero_cur = 0;
	logic bias_por_ok = 0, driver_supply_por_ok = 0, feedback_node_above_ref = 1;
	logic threshold_enable_input_rise = 0, threshold_enable_input_fall = 0;
	logic setpoint_select_lo = 0, setpoint_select_hi = 0, oc_trip = 0;
	logic uv_below_lo = 0, uv_above_hi = 1, ov_above_ref = 0, ov_below_ref_rel = 1;
	logic ov_above_fixed = 0, ov_below_fixed_rel = 1, local_output_sense_high = 0;
	logic [NPH-1:0] pwm_in = '0, sw_node_trip, low_side_gate_below;
	logic [NPH-1:0] high_side_gate_margin_low, sw_node_low;
	logic [NPH-1:0] high_side_gate_r, low_side_gate_r, gate_drive_oe_r;
	logic [6:0] ref_code_r;
	logic [3:0] sense_offset_r;
	logic output_ok_flag_oe_r, overvoltage_trip_r;
	logic [15:0] lfsr = 16'h2EED;
	int miscompares = 0, check_count = 0, cyc = 0;

	// ============================================================
	// design, far side, clock and stimulus
	bsq_sequencer #(.NPH(NPH), .HICCUP_CYC(8)) dut_u (.*);
	bsq_fet_model fet_u (.core_clk, .zero_cur, .hs(high_side_gate_r), .ls(low_side_gate_r),
		.oe(gate_drive_oe_r), .ls_below(low_side_gate_below), .node_trip(sw_node_trip),
		.hs_low(high_side_gate_margin_low), .node_low(sw_node_low));
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		#1;
		if (cyc > 40000) begin
			miscompares++;
			print_verdict();
		end else begin
			sw_tick = (cyc % 4 == 0);
			if (cyc % 8 == 0) begin
				lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
				pwm_in = lfsr[1:0];
			end
		end
	end

	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_tick();
		do @(posedge core_clk); while (sw_tick !== 1'b1);
		#1;
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// model: setpoint t codes of 12.5 mv, ramp of 16 ticks per code after 64
	task automatic soft_start(int sel, int fdbk_drop);
		int t;
		int n;
		t = 48 + 24 * sel;
		{setpoint_select_hi, setpoint_select_lo} = 2'(sel);
		feedback_node_above_ref = 1;
		{driver_supply_por_ok, threshold_enable_input_rise, threshold_enable_input_fall} = 3'h7;
		n = 0;
		while (output_ok_flag_oe_r === 1'b1 && n < 3000) begin
			wait_tick();
			n++;
			if (n == 2) check("offset start", sense_offset_r, 8);
			if (n == 60) check("delay ref", ref_code_r, 0);
			if (n == 100) check("drives held", gate_drive_oe_r, 0);
			if (n == 200) {ov_above_ref, ov_below_ref_rel} = 2'b10;
			if (n == 202) check("ov start", overvoltage_trip_r, 0);
			if (n == 203) {ov_above_fixed, ov_below_fixed_rel} = 2'b10;
			if (n == 205) check("ov fixed", overvoltage_trip_r, 1);
			if (n == 205) {ov_above_ref, ov_below_ref_rel, ov_above_fixed} = 3'b010;
			if (n == 207) check("ov fixed held", overvoltage_trip_r, 1);
			if (n == 207) ov_below_fixed_rel = 1;
			if (n == 209) check("ov fixed clear", overvoltage_trip_r, 0);
			if (n == 386) check("coarse", ref_code_r inside {[18:22]}, 1);
			if (n == 709) check("window", {sense_offset_r == 0, ref_code_r inside {[38:42]}}, 3);
			if (n == fdbk_drop) feedback_node_above_ref = 0;
			if (n == fdbk_drop + 4) check("drives on", gate_drive_oe_r, 3);
		end
		check("start ticks", n inside {[62 + 16 * t:66 + 16 * t]}, 1);
		check("setpoint", ref_code_r, t);
		step(2);
		check("drives run", gate_drive_oe_r, 3);
		threshold_enable_input_rise = 0;
		step(8);
		check("hysteresis", output_ok_flag_oe_r, 0);
	endtask

	task automatic faults();
		{uv_above_hi, uv_below_lo} = 2'b01;
		step(8);
		check("uv", {output_ok_flag_oe_r, gate_drive_oe_r}, 7);
		uv_below_lo = 0;
		step(8);
		check("uv hold", output_ok_flag_oe_r, 1);
		uv_above_hi = 1;
		step(8);
		check("uv clear", output_ok_flag_oe_r, 0);
		repeat (2) begin
			{ov_above_ref, ov_below_ref_rel} = 2'b10;
			step(8);
			check("ov trip", {overvoltage_trip_r, low_side_gate_r}, 7);
			ov_above_ref = 0;
			step(8);
			check("ov held", overvoltage_trip_r, 1);
			ov_below_ref_rel = 1;
			step(8);
			check("ov clear", {overvoltage_trip_r, output_ok_flag_oe_r, ref_code_r}, 72);
		end
		oc_trip = 1;
		step(8);
		check("oc off", {gate_drive_oe_r, output_ok_flag_oe_r}, 1);
		oc_trip = 0;
		repeat (12) wait_tick();
		check("oc retry", sense_offset_r, 8);
		local_output_sense_high = 1;
		step(8);
		check("sense fault", {ref_code_r, sense_offset_r}, 0);
		local_output_sense_high = 0;
		step(8);
		check("sense restart", sense_offset_r, 8);
	endtask

	initial begin
		int n;
		step(5);
		rst_n = 1;
		step(1);
		check("reset", {output_ok_flag_oe_r, gate_drive_oe_r, overvoltage_trip_r}, 8);
		{bias_por_ok, threshold_enable_input_rise, threshold_enable_input_fall} = 3'h7;
		step(20);
		check("no driver supply", {output_ok_flag_oe_r, sense_offset_r}, 16);
		for (int sel = 0; sel < 4; sel++) begin
			soft_start(sel, (sel == 3) ? 5000 : 800);
			if (sel == 1) faults();
			if (sel == 2) begin
				zero_cur = 1;
				n = 0;
				repeat (400) begin
					step(1);
					n += int'(high_side_gate_r[0]);
				end
				check("zero current", n > 0, 1);
				zero_cur = 0;
			end
			{threshold_enable_input_rise, threshold_enable_input_fall} = 2'b00;
			step(8);
			check("shutdown", {output_ok_flag_oe_r, gate_drive_oe_r, ref_code_r}, 16'h0200);
		end
		print_verdict();
	end
endmodule // bsq_sequencer_tb

bind bsq_sequencer bsq_sequencer_sva #(.NPH(NPH)) chk_u (.core_clk, .rst_n,
	.low_side_gate_below, .high_side_gate_margin_low, .sw_node_low, .high_side_gate_r,
	.low_side_gate_r, .gate_drive_oe_r, .ref_code_r, .sense_offset_r, .output_ok_flag_oe_r,
	.overvoltage_trip_r);
